// *** ccrb_pkg.sv ***
// package: register map, field positions and reset values of the converter register bank
package ccrb_pkg;

    // ****************************************
    // register addresses
    // ****************************************
    localparam logic [3:0] ADDR_MAIN_CONFIG   = 4'h0;
    localparam logic [3:0] ADDR_RSVD_ONE      = 4'h1;
    localparam logic [3:0] ADDR_INPHASE_OFS   = 4'h2;
    localparam logic [3:0] ADDR_INPHASE_FS    = 4'h3;
    localparam logic [3:0] ADDR_CAL_ADJUST    = 4'h4;
    localparam logic [3:0] ADDR_CAL_VALUES    = 4'h5;
    localparam logic [3:0] ADDR_RSVD_SIX      = 4'h6;
    localparam logic [3:0] ADDR_INTERLEAVE_TM = 4'h7;
    localparam logic [3:0] ADDR_RSVD_EIGHT    = 4'h8;
    localparam logic [3:0] ADDR_RSVD_NINE     = 4'h9;
    localparam logic [3:0] ADDR_QUAD_OFS      = 4'ha;
    localparam logic [3:0] ADDR_QUAD_FS       = 4'hb;
    localparam logic [3:0] ADDR_APERTURE_CRS  = 4'hc;
    localparam logic [3:0] ADDR_APERTURE_FINE = 4'hd;
    localparam logic [3:0] ADDR_MULTI_SYNC    = 4'he;
    localparam logic [3:0] ADDR_RSVD_FIFTEEN  = 4'hf;

    localparam int NUM_SLOTS = 16;
    localparam int REG_WIDTH = 16;

    // ****************************************
    // main configuration field positions
    // ****************************************
    localparam int BIT_CAL_TRIGGER     = 15;
    localparam int BIT_CLK_PHASE_SEL   = 14;
    localparam int BIT_OUT_VOLT_SEL    = 13;
    localparam int BIT_TEST_PATTERN    = 12;
    localparam int BIT_PWR_DN_INPHASE  = 11;
    localparam int BIT_PWR_DN_QUAD     = 10;
    localparam int BIT_INTERLEAVE      = 7;
    localparam int BIT_INTERLEAVE_Q    = 6;
    localparam int BIT_INTERLEAVE_IQ   = 5;
    localparam int BIT_TWOS_COMPLEMENT = 4;
    localparam int BIT_TIME_STAMP      = 3;
    localparam int BIT_SINGLE_RATE     = 2;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [15:0] RST_MAIN_CONFIG = 16'h2000;
    localparam logic [15:0] RST_OTHER       = 16'h0000;
    localparam logic [15:0] RD_RESERVED     = 16'h0000;

    // true for the eleven read/write slots
    function automatic logic is_rw_slot(input logic [3:0] a);
        return !(a == ADDR_RSVD_ONE || a == ADDR_RSVD_SIX || a == ADDR_RSVD_EIGHT ||
                 a == ADDR_RSVD_NINE || a == ADDR_RSVD_FIFTEEN);
    endfunction

endpackage

// *** ccrb_register_bank.sv ***
// converter control register bank: sixteen-slot map, main configuration decode
`timescale 1ns/1ps

module ccrb_register_bank (
    input  wire logic        I_SYS_CLK,
    input  wire logic        I_RESET,
    input  wire logic        I_CLK_EN,
    input  wire logic        I_EXT_CTRL_MODE,
    input  wire logic        I_WR_EN,
    input  wire logic        I_RD_EN,
    input  wire logic [3:0]  I_ADDR,
    input  wire logic [15:0] I_WR_DATA,
    input  wire logic        I_PIN_SINGLE_RATE,
    input  wire logic        I_PIN_CLK_PHASE_SEL,
    input  wire logic        I_PIN_CAL_TRIGGER,
    output logic [15:0]      O_RD_DATA,
    output logic             O_RD_VALID,
    output logic             O_CAL_START,
    output logic             O_SINGLE_RATE,
    output logic             O_CLK_PHASE_90,
    output logic             O_DATA_ON_FALLING,
    output logic             O_OUT_VOLT_SEL,
    output logic             O_TEST_PATTERN,
    output logic             O_PWR_DN_INPHASE,
    output logic             O_PWR_DN_QUAD,
    output logic             O_TWOS_COMPLEMENT,
    output logic             O_TIME_STAMP,
    output logic [15:0]      O_MAIN_CONFIG
);

    // ****************************************
    // storage and decode
    // ****************************************
    logic [15:0] regs_r [ccrb_pkg::NUM_SLOTS];
    logic [15:0] rd_data_nxt;
    logic        cal_level_r;
    logic        wr_hit;
    logic [15:0] cfg;
    logic        cal_req;
    logic        single_rate;
    logic        phase_sel;

    assign wr_hit = I_WR_EN && ccrb_pkg::is_rw_slot(I_ADDR);

    assign rd_data_nxt = ccrb_pkg::is_rw_slot(I_ADDR) ? regs_r[I_ADDR]
                                                       : ccrb_pkg::RD_RESERVED;

    generate
        for (genvar g = 0; g < ccrb_pkg::NUM_SLOTS; g++) begin : g_slot
            always_ff @(posedge I_SYS_CLK) begin
                if (I_RESET) begin
                    regs_r[g] <= (g == ccrb_pkg::ADDR_MAIN_CONFIG) ?
                                 ccrb_pkg::RST_MAIN_CONFIG : ccrb_pkg::RST_OTHER;
                end else if (I_CLK_EN && wr_hit && I_ADDR == 4'(g)) begin
                    regs_r[g] <= I_WR_DATA;
                end
            end
        end
    endgenerate

    // ****************************************
    // mode selection
    // ****************************************
    assign cfg = regs_r[ccrb_pkg::ADDR_MAIN_CONFIG];

    assign single_rate = I_EXT_CTRL_MODE ? cfg[ccrb_pkg::BIT_SINGLE_RATE] : I_PIN_SINGLE_RATE;
    assign phase_sel   = I_EXT_CTRL_MODE ? cfg[ccrb_pkg::BIT_CLK_PHASE_SEL]
                                         : I_PIN_CLK_PHASE_SEL;
    assign cal_req     = I_EXT_CTRL_MODE ? cfg[ccrb_pkg::BIT_CAL_TRIGGER] : I_PIN_CAL_TRIGGER;

    // ****************************************
    // output flops
    // ****************************************
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            O_RD_DATA   <= 16'h0000;
            O_RD_VALID  <= 1'b0;
            cal_level_r <= 1'b0;
            O_CAL_START <= 1'b0;
        end else if (I_CLK_EN) begin
            O_RD_DATA   <= I_RD_EN ? rd_data_nxt : O_RD_DATA;
            O_RD_VALID  <= I_RD_EN;
            cal_level_r <= cal_req;
            O_CAL_START <= cal_req && !cal_level_r;
        end
    end

    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            O_SINGLE_RATE     <= 1'b0;
            O_CLK_PHASE_90    <= 1'b0;
            O_DATA_ON_FALLING <= 1'b0;
            O_OUT_VOLT_SEL    <= 1'b1;
            O_TEST_PATTERN    <= 1'b0;
            O_PWR_DN_INPHASE  <= 1'b0;
            O_PWR_DN_QUAD     <= 1'b0;
            O_TWOS_COMPLEMENT <= 1'b0;
            O_TIME_STAMP      <= 1'b0;
            O_MAIN_CONFIG     <= ccrb_pkg::RST_MAIN_CONFIG;
        end else if (I_CLK_EN) begin
            O_SINGLE_RATE     <= single_rate;
            O_CLK_PHASE_90    <= !single_rate && phase_sel;
            O_DATA_ON_FALLING <= single_rate && phase_sel;
            O_OUT_VOLT_SEL    <= I_EXT_CTRL_MODE ? cfg[ccrb_pkg::BIT_OUT_VOLT_SEL] : 1'b1;
            O_TEST_PATTERN    <= I_EXT_CTRL_MODE && cfg[ccrb_pkg::BIT_TEST_PATTERN];
            O_PWR_DN_INPHASE  <= I_EXT_CTRL_MODE && cfg[ccrb_pkg::BIT_PWR_DN_INPHASE];
            O_PWR_DN_QUAD     <= I_EXT_CTRL_MODE && cfg[ccrb_pkg::BIT_PWR_DN_QUAD];
            O_TWOS_COMPLEMENT <= I_EXT_CTRL_MODE && cfg[ccrb_pkg::BIT_TWOS_COMPLEMENT];
            O_TIME_STAMP      <= I_EXT_CTRL_MODE && cfg[ccrb_pkg::BIT_TIME_STAMP];
            O_MAIN_CONFIG     <= cfg;
        end
    end

endmodule

// *** ccrb_checker_properties.sv ***
// checker: timing relations at the register bank ports
`timescale 1ns/1ps
module ccrb_checker (
    input wire logic I_SYS_CLK, I_RESET, I_CLK_EN, I_EXT_CTRL_MODE, I_RD_EN, I_WR_EN,
    input wire logic [3:0] I_ADDR,
    input wire logic [15:0] I_WR_DATA, O_RD_DATA, O_MAIN_CONFIG,
    input wire logic O_RD_VALID, O_CAL_START, O_SINGLE_RATE, O_CLK_PHASE_90,
    input wire logic O_DATA_ON_FALLING, O_OUT_VOLT_SEL, O_TEST_PATTERN
);
    default clocking @(posedge I_SYS_CLK); endclocking
    default disable iff (I_RESET);
    a_read_answer: assert property (I_CLK_EN && I_RD_EN |=> O_RD_VALID)
        else $error("read not answered");
    a_reserved_zero: assert property (I_CLK_EN && I_RD_EN &&
        (I_ADDR inside {4'h1, 4'h6, 4'h8, 4'h9, 4'hf}) |=> O_RD_DATA == 16'h0000)
        else $error("reserved slot read not zero");
    a_config_copy: assert property (I_CLK_EN && I_WR_EN && I_ADDR == 4'h0 ##1 I_CLK_EN
        |=> O_MAIN_CONFIG == $past(I_WR_DATA, 2)) else $error("config copy wrong");
    a_cal_one_pulse: assert property (O_CAL_START && I_CLK_EN |=> !O_CAL_START)
        else $error("calibration pulse too long");
    a_rate_follow: assert property ($past(I_CLK_EN) && $past(I_EXT_CTRL_MODE) |->
        O_SINGLE_RATE == O_MAIN_CONFIG[2] && O_OUT_VOLT_SEL == O_MAIN_CONFIG[13])
        else $error("rate or voltage not from config");
    a_phase_double: assert property ($past(I_CLK_EN) && $past(I_EXT_CTRL_MODE) |->
        O_CLK_PHASE_90 == (O_MAIN_CONFIG[14] && !O_MAIN_CONFIG[2])) else $error("phase wrong");
    a_edge_single: assert property ($past(I_CLK_EN) && $past(I_EXT_CTRL_MODE) |->
        O_DATA_ON_FALLING == (O_MAIN_CONFIG[14] && O_MAIN_CONFIG[2])) else $error("edge wrong");
    a_pin_defaults: assert property ($past(I_CLK_EN) && !$past(I_EXT_CTRL_MODE) |->
        O_OUT_VOLT_SEL && !O_TEST_PATTERN) else $error("pin mode fields not default");
endmodule
bind ccrb_register_bank ccrb_checker chk_u (.I_SYS_CLK, .I_RESET, .I_CLK_EN, .I_EXT_CTRL_MODE,
    .I_RD_EN, .I_WR_EN, .I_ADDR, .I_WR_DATA, .O_RD_DATA, .O_MAIN_CONFIG, .O_RD_VALID,
    .O_CAL_START, .O_SINGLE_RATE, .O_CLK_PHASE_90, .O_DATA_ON_FALLING, .O_OUT_VOLT_SEL,
    .O_TEST_PATTERN);

// *** ccrb_host_model.sv ***
// host model: drives the register port from the falling clock edge
`timescale 1ns/1ps
module ccrb_host_model (
    input  wire logic        i_clk,
    input  wire logic [15:0] i_rd_data,
    output logic             o_wr_en,
    output logic             o_rd_en,
    output logic [3:0]       o_addr,
    output logic [15:0]      o_wr_data
);
    initial {o_wr_en, o_rd_en, o_addr, o_wr_data} = 22'h0;
    // callers keep reserved bits at default, never double rate with demux
    task automatic xfer(input logic w, input logic [3:0] a, input logic [15:0] dw,
                        output logic [15:0] dr);
        @(negedge i_clk);
        {o_wr_en, o_rd_en, o_addr, o_wr_data} = {w, ~w, a, dw};
        @(negedge i_clk);
        {o_wr_en, o_rd_en, o_addr, o_wr_data} = {2'h0, ~a, ~dw};
        @(negedge i_clk);
        dr = i_rd_data;
    endtask
endmodule

// *** converter_control_register_bank_tb_top.sv ***
// testbench: register map, mode decode and calibration trigger
`timescale 1ns/1ps
module converter_control_register_bank_tb_top;
    logic clk = 1'h0, rst = 1'h1, ext = 1'h1, p_sdr = 1'h0, p_ph = 1'h0, p_cal = 1'h0;
    logic we, re, cal, single_rate_output, ph, fall, volt, ce = 1'h1, tp, power_down_inphase_channel, power_down_quadrature_channel, twos, ts, rv;
    logic [15:0] mcfg;
    int valids = 0;
    logic [3:0] ad;
    logic [15:0] wd, rdat, d;
    int tests_run = 0, bad_count = 0, pulses = 0;
    always #2.5 clk = ~clk;
    // outputs are counted at the falling edge, away from the launching edge
    always @(negedge clk) begin
        if (cal === 1'h1) pulses++;
        if (rv === 1'h1) valids++;
    end
    ccrb_register_bank dut_u (.I_SYS_CLK(clk), .I_RESET(rst), .I_CLK_EN(ce),
        .I_EXT_CTRL_MODE(ext), .I_WR_EN(we), .I_RD_EN(re), .I_ADDR(ad), .I_WR_DATA(wd),
        .I_PIN_SINGLE_RATE(p_sdr), .I_PIN_CLK_PHASE_SEL(p_ph), .I_PIN_CAL_TRIGGER(p_cal),
        .O_RD_DATA(rdat), .O_RD_VALID(rv), .O_CAL_START(cal), .O_SINGLE_RATE(single_rate_output),
        .O_CLK_PHASE_90(ph), .O_DATA_ON_FALLING(fall), .O_OUT_VOLT_SEL(volt),
        .O_TEST_PATTERN(tp), .O_PWR_DN_INPHASE(power_down_inphase_channel), .O_PWR_DN_QUAD(power_down_quadrature_channel),
        .O_TWOS_COMPLEMENT(twos), .O_TIME_STAMP(ts), .O_MAIN_CONFIG(mcfg));
    ccrb_host_model host_u (.i_clk(clk), .i_rd_data(rdat), .o_wr_en(we), .o_rd_en(re),
        .o_addr(ad), .o_wr_data(wd));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge clk);
        rst = 1'h0;
        for (int a = 0; a < 16; a++) begin
            host_u.xfer(1'h0, a[3:0], 16'h0000, d);
            check(d, (a == 0) ? 16'h2000 : 16'h0000);
        end
        check(valids[15:0], 16'h0010);
        for (int a = 1; a < 16; a++) begin
            host_u.xfer(1'h1, a[3:0], {a[3:0], 8'h5a, ~a[3:0]}, d);
            host_u.xfer(1'h0, a[3:0], 16'h0000, d);
            check(d, (a inside {1, 6, 8, 9, 15}) ? 16'h0000 : {a[3:0], 8'h5a, ~a[3:0]});
        end
        // a write while the clock enable is low must not land
        ce = 1'h0;
        host_u.xfer(1'h1, 4'h2, 16'h1234, d);
        ce = 1'h1;
        host_u.xfer(1'h0, 4'h2, 16'h0000, d);
        check(d, 16'h25ad);
        host_u.xfer(1'h1, 4'h0, 16'h3c18, d);
        check({11'h0, tp, power_down_inphase_channel, power_down_quadrature_channel, twos, ts}, 16'h001f);
        check(mcfg, 16'h3c18);
        for (int m = 0; m < 4; m++) begin
            host_u.xfer(1'h1, 4'h0, {1'h0, m[1], 11'h400, m[0], 2'h0}, d);
            check({13'h0, single_rate_output, ph, fall}, {13'h0, m[0], m[1] & ~m[0], m[1] & m[0]});
        end
        pulses = 0;
        host_u.xfer(1'h1, 4'h0, 16'ha000, d);
        host_u.xfer(1'h1, 4'h0, 16'ha000, d);
        check(pulses[15:0], 16'h0001);
        host_u.xfer(1'h1, 4'h0, 16'h2000, d);
        host_u.xfer(1'h1, 4'h0, 16'ha000, d);
        @(negedge clk);
        check(pulses[15:0], 16'h0002);
        host_u.xfer(1'h1, 4'h0, 16'h0000, d);
        ext = 1'h0;
        p_sdr = 1'h1;
        p_ph = 1'h1;
        p_cal = 1'h1;
        repeat (3) @(negedge clk);
        check({12'h0, single_rate_output, fall, volt, pulses == 3}, 16'h000f);
        report_and_stop();
    end
    initial begin
        #20000;
        bad_count++;
        report_and_stop();
    end
endmodule
